// file: core/spdc_sleep_ctrl.v
`include "spdc_defs.vh"
`default_nettype none

module spdc_sleep_ctrl (
    input wire aclk,
    input wire aresetn,
    // cpu side, same clock domain
    input wire sleep_exec,
    input wire [7:0] irq_flags,
    input wire [7:0] irq_enables,
    input wire global_interrupt_enable,
    input wire watchdog_timeout,
    // external reset pins, synchronised; the io and clock-source requests after them are used unsynchronised
    input wire master_clear_pin_n,
    input wire brownout_reset,
    input wire por_reset,
    input wire [5:0] io_out_req,
    input wire [5:0] io_oe_n_req,
    input wire lp_incompatible_periph_en,
    input wire timer_a_sleep_src,
    input wire adc_rc_selected,
    input wire cwg_uses_hfosc,
    output reg cpu_clk_en,
    output reg prefetch_next,
    output reg resume_pulse,
    output reg vector_isr,
    output reg watchdog_clear,
    output reg watchdog_run_in_sleep,
    output reg device_reset,
    output reg power_down_flag,
    output reg timeout_flag,
    output reg regulator_lp_active,
    output reg low_freq_internal_osc_en,
    output reg timer_a_clk_en,
    output reg adc_clk_en,
    output reg high_freq_internal_osc_en,
    output reg [5:0] io_out,
    output reg [5:0] io_oe_n,
    // axi4-lite slave
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    localparam ST_AWAKE = 2'b00;
    localparam ST_SLEEP = 2'b01;
    localparam ST_SETTLE = 2'b10;
    // the settle counter runs down to zero, so it is loaded with one less than the settle length
    localparam integer SETTLE_LOAD_INT = `SPDC_SETTLE_CYC - 1;
    localparam [`SPDC_CNT_W-1:0] SETTLE_LOAD = SETTLE_LOAD_INT[`SPDC_CNT_W-1:0];

    // two-flop synchronisers for pin-level inputs
    reg [2:0] pin_s1_reg;
    reg [2:0] pin_s2_reg;
    wire master_clear_pin_hit = ~pin_s2_reg[0];
    wire bor_hit = pin_s2_reg[1];
    wire por_hit = pin_s2_reg[2];
    wire hard_reset = master_clear_pin_hit | bor_hit | por_hit;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [`SPDC_CNT_W-1:0] settle_reg;
    reg lp_select_reg;
    reg unreg_variant_reg;
    reg wdt_sleep_en_reg;

    wire irq_pending = |(irq_flags & irq_enables);
    wire sleep_takes = sleep_exec & ~irq_pending;
    wire lp_sleep = lp_select_reg & ~lp_incompatible_periph_en & ~unreg_variant_reg;
    wire wake_event = irq_pending | watchdog_timeout;
    wire asleep = (state_reg == ST_SLEEP);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_reg <= 3'h1;
            pin_s2_reg <= 3'h1;
        end
        else
        begin
            pin_s1_reg <= {por_reset, brownout_reset, master_clear_pin_n};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_AWAKE:
                if (sleep_takes)
                    state_next = ST_SLEEP;
            ST_SLEEP:
                if (wake_event)
                    state_next = regulator_lp_active ? ST_SETTLE : ST_AWAKE;
            ST_SETTLE:
                if (settle_reg == {`SPDC_CNT_W{1'b0}})
                    state_next = ST_AWAKE;
            default:
                state_next = ST_AWAKE;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn || hard_reset)
        begin
            state_reg <= ST_AWAKE;
            settle_reg <= {`SPDC_CNT_W{1'b0}};
            cpu_clk_en <= 1'b1;
            prefetch_next <= 1'b0;
            resume_pulse <= 1'b0;
            vector_isr <= 1'b0;
            watchdog_clear <= 1'b0;
            power_down_flag <= 1'b1;
            timeout_flag <= 1'b1;
            regulator_lp_active <= 1'b0;
            io_out <= 6'h00;
            io_oe_n <= 6'h3f;
        end
        else
        begin
            state_reg <= state_next;
            prefetch_next <= 1'b0;
            resume_pulse <= 1'b0;
            vector_isr <= 1'b0;
            watchdog_clear <= 1'b0;
            if (state_reg == ST_AWAKE && sleep_takes)
            begin
                prefetch_next <= 1'b1;
                watchdog_clear <= 1'b1;
                power_down_flag <= 1'b0;
                timeout_flag <= 1'b1;
                cpu_clk_en <= 1'b0;
                regulator_lp_active <= lp_sleep;
                io_out <= io_out_req;
                io_oe_n <= io_oe_n_req;
            end
            if (asleep && wake_event)
            begin
                watchdog_clear <= 1'b1;
                regulator_lp_active <= 1'b0;
                settle_reg <= SETTLE_LOAD;
                if (watchdog_timeout && !irq_pending)
                    timeout_flag <= 1'b0;
            end
            if (state_reg == ST_SETTLE && settle_reg != {`SPDC_CNT_W{1'b0}})
                settle_reg <= settle_reg - 1'b1;
            if (state_next == ST_AWAKE && state_reg != ST_AWAKE)
            begin
                cpu_clk_en <= 1'b1;
                resume_pulse <= 1'b1;
                vector_isr <= global_interrupt_enable & irq_pending;
            end
            if (state_reg == ST_AWAKE && !sleep_takes)
            begin
                io_out <= io_out_req;
                io_oe_n <= io_oe_n_req;
            end
        end
    end

    // oscillator and peripheral clock enables
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            low_freq_internal_osc_en <= 1'b1;
            timer_a_clk_en <= 1'b1;
            adc_clk_en <= 1'b1;
            high_freq_internal_osc_en <= 1'b1;
            watchdog_run_in_sleep <= 1'b0;
        end
        else
        begin
            low_freq_internal_osc_en <= 1'b1;
            timer_a_clk_en <= ~asleep | timer_a_sleep_src;
            adc_clk_en <= ~asleep | adc_rc_selected;
            high_freq_internal_osc_en <= ~asleep | cwg_uses_hfosc;
            watchdog_run_in_sleep <= asleep & wdt_sleep_en_reg;
            device_reset <= hard_reset;
        end
    end

    // axi4-lite slave, one word per register
    reg aw_hold_reg;
    reg w_hold_reg;
    reg [3:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_hold_reg | aw_fire;
    wire w_have = w_hold_reg | w_fire;
    wire [3:0] wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
    wire [3:0] wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
    wire do_write = aw_have & w_have & ~s_axi_bvalid;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SPDC_RESP_OKAY;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            lp_select_reg <= 1'b0;
            unreg_variant_reg <= 1'b0;
            wdt_sleep_en_reg <= 1'b0;
        end
        else
        begin
            if (aw_fire)
            begin
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_fire)
            begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            aw_hold_reg <= aw_have & ~do_write;
            w_hold_reg <= w_have & ~do_write;
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `SPDC_RESP_OKAY;
                case (wr_addr)
                    `SPDC_ADDR_REGCTL:
                        if (wr_strb[0])
                            lp_select_reg <= wr_data[`SPDC_REG_LP_BIT];
                    `SPDC_ADDR_WAKECFG:
                        if (wr_strb[0])
                        begin
                            unreg_variant_reg <= wr_data[`SPDC_WC_UNREG_BIT];
                            wdt_sleep_en_reg <= wr_data[`SPDC_WC_WDT_SLEEP_BIT];
                        end
                    `SPDC_ADDR_STATUS:
                        ;
                    default:
                        s_axi_bresp <= `SPDC_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SPDC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `SPDC_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            case (s_axi_araddr)
                `SPDC_ADDR_REGCTL:
                begin
                    // reserved bit always reads one; low-power bit invisible on unregulated variant
                    s_axi_rdata[`SPDC_REG_RSVD_BIT] <= 1'b1;
                    s_axi_rdata[`SPDC_REG_LP_BIT] <= lp_select_reg & ~unreg_variant_reg;
                end
                `SPDC_ADDR_STATUS:
                begin
                    s_axi_rdata[`SPDC_ST_PD_BIT] <= power_down_flag;
                    s_axi_rdata[`SPDC_ST_TO_BIT] <= timeout_flag;
                    s_axi_rdata[`SPDC_ST_ASLEEP_BIT] <= ~cpu_clk_en;
                    s_axi_rdata[`SPDC_ST_LPACT_BIT] <= regulator_lp_active;
                end
                `SPDC_ADDR_WAKECFG:
                begin
                    s_axi_rdata[`SPDC_WC_UNREG_BIT] <= unreg_variant_reg;
                    s_axi_rdata[`SPDC_WC_WDT_SLEEP_BIT] <= wdt_sleep_en_reg;
                end
                default:
                    s_axi_rresp <= `SPDC_RESP_SLVERR;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// file: pkg/spdc_defs.vh
`ifndef SPDC_DEFS_VH
`define SPDC_DEFS_VH

// register byte addresses
`define SPDC_ADDR_REGCTL 4'h0
`define SPDC_ADDR_STATUS 4'h4
`define SPDC_ADDR_WAKECFG 4'h8

// regulator control fields
`define SPDC_REG_RSVD_BIT 0
`define SPDC_REG_LP_BIT 1
`define SPDC_REG_RESET 8'h01

// status fields
`define SPDC_ST_PD_BIT 0
`define SPDC_ST_TO_BIT 1
`define SPDC_ST_ASLEEP_BIT 2
`define SPDC_ST_LPACT_BIT 3

// wake configuration fields
`define SPDC_WC_UNREG_BIT 0
`define SPDC_WC_WDT_SLEEP_BIT 1

// axi responses
`define SPDC_RESP_OKAY 2'b00
`define SPDC_RESP_SLVERR 2'b10

// regulator settle time after low-power sleep
`define SPDC_SETTLE_NS 2000
`define SPDC_CLK_NS 10
`define SPDC_SETTLE_CYC ((`SPDC_SETTLE_NS + `SPDC_CLK_NS - 1) / `SPDC_CLK_NS)
`define SPDC_CNT_W 8

`endif

// file: testbench/sleep_power_down_control_tb_top.sv
`include "spdc_defs.vh"
`default_nettype none
module sleep_power_down_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, sleep_exec, global_interrupt_enable, watchdog_timeout, master_clear_pin_n, brownout_reset;
    logic por_reset, lp_incompatible_periph_en, timer_a_sleep_src, adc_rc_selected, cwg_uses_hfosc, cpu_clk_en;
    logic prefetch_next, resume_pulse, vector_isr, watchdog_clear, watchdog_run_in_sleep, device_reset;
    logic power_down_flag, timeout_flag, regulator_lp_active, low_freq_internal_osc_en, timer_a_clk_en;
    logic adc_clk_en, high_freq_internal_osc_en, sleep_req, vec_seen, rst_seen, seen_clr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] irq_flags, irq_enables, irq_raise;
    logic [5:0] io_out_req, io_oe_n_req, io_out, io_oe_n;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, r, q;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int n_mismatch, check_count, src, n, pd, to, lp, inc, unr, lpx;
    spdc_sleep_ctrl u_dut (.*);
    spdc_cpu_model u_cpu (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        // no cycle count is assumed: only the bench watchdog ends a hung wait
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
        q = s_axi_rdata;
        rs = wr ? s_axi_bresp : s_axi_rresp;
        {s_axi_bready, s_axi_rready} <= 2'b00;
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        if (seen_clr)
            {vec_seen, rst_seen} <= 2'b00;
        else
        begin
            if (vector_isr === 1'b1) vec_seen <= 1'b1;
            if (device_reset === 1'b1) rst_seen <= 1'b1;
        end
    end
    initial
    begin
        repeat (30000) @(posedge aclk);
        n_mismatch++;
        print_verdict();
    end
    initial
    begin
        {sleep_req, irq_raise, irq_enables, global_interrupt_enable, brownout_reset, por_reset, aresetn,
            lp_incompatible_periph_en, timer_a_sleep_src, adc_rc_selected, cwg_uses_hfosc, io_out_req, s_axi_awaddr,
            s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {master_clear_pin_n, io_oe_n_req, s_axi_wstrb, seen_clr} = '1;
        {n_mismatch, check_count, pd, to} = {32'd0, 32'd0, 32'd1, 32'd1};
        r = 32'h9b04;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi(0, `SPDC_ADDR_STATUS, 0);
        chk(q, 32'h3);
        axi(0, 4'hc, 0);
        chk({q[29:0], rs}, {30'h0, `SPDC_RESP_SLVERR});
        axi(1, 4'hc, 0);
        chk(rs, `SPDC_RESP_SLVERR);
        // src: 0 irq, 1 watchdog, 2 no-op, 3 late irq, 4..6 pin resets
        for (int i = 0; i < 14; i++)
        begin
            r = lfsr(r);
            src = i % 7;
            lp = r[1] | (i < 7);
            inc = r[2] & (i > 6);
            unr = r[4] & r[5] & (i > 6);
            lpx = lp & !inc & !unr;
            axi(1, `SPDC_ADDR_WAKECFG, {src == 1, unr[0]});
            chk(rs, `SPDC_RESP_OKAY);
            axi(1, `SPDC_ADDR_REGCTL, {r[31:2], lp[0], 1'b1});
            axi(0, `SPDC_ADDR_REGCTL, 0);
            chk(q, {lp[0] & !unr[0], 1'b1});
            {cwg_uses_hfosc, adc_rc_selected, timer_a_sleep_src, global_interrupt_enable} <= r[8:5];
            {io_out_req, io_oe_n_req, lp_incompatible_periph_en} <= {r[20:9], inc[0]};
            irq_enables <= {1'b0, r[27:21]} | 8'h01;
            repeat (3) @(posedge aclk);
            {seen_clr, sleep_req} <= 2'b11;
            if (src == 2) irq_raise <= irq_enables;
            @(posedge aclk);
            {seen_clr, sleep_req} <= 2'b00;
            if (src == 3) irq_raise <= irq_enables;
            repeat (4) @(posedge aclk);
            if (src != 2 && src != 3)
            begin
                {io_out_req, io_oe_n_req} <= ~r[20:9];
                axi(0, `SPDC_ADDR_STATUS, 0);
                chk(q, {lpx[0], 3'b110});
                chk({timer_a_clk_en, adc_clk_en, high_freq_internal_osc_en, low_freq_internal_osc_en, io_out, io_oe_n},
                    {r[6], r[7], r[8], 1'b1, r[20:9]});
                if (src == 0) irq_raise <= ~irq_enables;
                repeat (5) @(posedge aclk);
                chk(cpu_clk_en, 1'b0);
                if (src == 0) irq_raise <= irq_enables;
                {master_clear_pin_n, brownout_reset, por_reset} <= {src != 4, src == 5, src == 6};
            end
            n = 0;
            while (cpu_clk_en !== 1'b1 && n < 600)
            begin
                @(posedge aclk);
                n++;
            end
            {irq_raise, brownout_reset, por_reset, master_clear_pin_n} <= 11'h001;
            repeat (5) @(posedge aclk);
            pd = (src == 2) ? pd : int'(src > 3);
            to = (src == 2) ? to : int'(src != 1);
            axi(0, `SPDC_ADDR_STATUS, 0);
            chk(q, {to[0], pd[0]});
            chk({vec_seen, rst_seen, n > 100}, {r[5] && (src == 0 || src == 3), src > 3,
                (src < 2 || src == 3) && lpx});
        end
        print_verdict();
    end
endmodule
`default_nettype wire

// file: testbench/spdc_cpu_model.sv
`default_nettype none
module spdc_cpu_model #(
    parameter int WDT_LIMIT = 40
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cpu_clk_en,
    input wire logic watchdog_clear,
    input wire logic watchdog_run_in_sleep,
    input wire logic sleep_req,
    input wire logic [7:0] irq_raise,
    output logic sleep_exec = 1'b0,
    output logic [7:0] irq_flags = 8'h00,
    output logic watchdog_timeout = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int wdt_cnt = 0;
    always @(posedge aclk)
    begin
        // a gated core cannot issue the sleep instruction
        sleep_exec <= sleep_req && cpu_clk_en;
        irq_flags <= irq_raise;
        if (!aresetn || watchdog_clear)
            wdt_cnt <= 0;
        else if (!cpu_clk_en && watchdog_run_in_sleep)
            wdt_cnt <= wdt_cnt + 1;
        watchdog_timeout <= (wdt_cnt == WDT_LIMIT);
    end
endmodule
`default_nettype wire

// file: testbench/spdc_sleep_ctrl_sva.sv
`default_nettype none
module spdc_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sleep_exec,
    input wire logic [7:0] irq_flags,
    input wire logic [7:0] irq_enables,
    input wire logic global_interrupt_enable,
    input wire logic watchdog_timeout,
    input wire logic cpu_clk_en,
    input wire logic prefetch_next,
    input wire logic resume_pulse,
    input wire logic vector_isr,
    input wire logic watchdog_clear,
    input wire logic power_down_flag,
    input wire logic timeout_flag,
    input wire logic regulator_lp_active,
    input wire logic [5:0] io_out,
    input wire logic [5:0] io_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend, wake, ent, slp, slp_q;
    assign pend = |(irq_flags & irq_enables);
    assign wake = pend || watchdog_timeout;
    assign ent = sleep_exec && cpu_clk_en && !pend;
    // asleep is only visible through a register, so it is tracked here
    // a pin reset ends sleep without a wake event; the running cpu clock shows it
    assign slp = slp_q && !cpu_clk_en;
    always_ff @(posedge aclk)
        slp_q <= aresetn && (ent || slp && !wake);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_only_by_sleep: assert property ($fell(cpu_clk_en) |-> $past(sleep_exec))
        else $error("cpu clock stopped without sleep");
    a_entry_flags: assert property (ent |=> !cpu_clk_en && !power_down_flag && timeout_flag)
        else $error("sleep entry state wrong");
    a_entry_wdt_clear: assert property (ent |=> watchdog_clear && prefetch_next)
        else $error("sleep entry pulses missing");
    a_sleep_nop: assert property (sleep_exec && cpu_clk_en && pend
        |=> cpu_clk_en && $stable(power_down_flag) && $stable(timeout_flag))
        else $error("pending interrupt did not make sleep a no-op");
    a_wake_wdt_clear: assert property (slp && wake |=> watchdog_clear)
        else $error("wake without watchdog clear");
    a_no_wake_unen: assert property (slp && |irq_flags && !wake |=> !cpu_clk_en && !watchdog_clear)
        else $error("woke on a disabled interrupt");
    a_fast_wake: assert property (slp && wake && !regulator_lp_active |=> ##[0:2] cpu_clk_en)
        else $error("normal-power wake too slow");
    a_lp_settle: assert property (slp && wake && regulator_lp_active
        |=> (!cpu_clk_en) [*8] ##[150:250] cpu_clk_en)
        else $error("low-power wake settle wrong");
    a_io_frozen: assert property (slp && !wake |=> cpu_clk_en || $stable(io_out) && $stable(io_oe_n))
        else $error("pins changed while asleep");
    a_vector_gie: assert property (vector_isr |-> resume_pulse && global_interrupt_enable)
        else $error("vector without resume or global enable");
    c_nop: cover property (sleep_exec && cpu_clk_en && pend);
    c_lp_wake: cover property (slp && wake && regulator_lp_active);
    c_vector: cover property (vector_isr);
endmodule
bind spdc_sleep_ctrl spdc_sva u_sva (
    .aclk(aclk),
    .aresetn(aresetn),
    .sleep_exec(sleep_exec),
    .irq_flags(irq_flags),
    .irq_enables(irq_enables),
    .global_interrupt_enable(global_interrupt_enable),
    .watchdog_timeout(watchdog_timeout),
    .cpu_clk_en(cpu_clk_en),
    .prefetch_next(prefetch_next),
    .resume_pulse(resume_pulse),
    .vector_isr(vector_isr),
    .watchdog_clear(watchdog_clear),
    .power_down_flag(power_down_flag),
    .timeout_flag(timeout_flag),
    .regulator_lp_active(regulator_lp_active),
    .io_out(io_out),
    .io_oe_n(io_oe_n)
);
`default_nettype wire
